// *** rtl/sls_cfg.svh ***
`ifndef SLS_CFG_SVH
`define SLS_CFG_SVH

// Selector codes
`define SLS_CODE_DISABLE 14'h270F
`define SLS_CODE_FREQ_AUX 14'h0000
`define SLS_CODE_FLUX 14'h0001
`define SLS_CODE_STALL 14'h0004
`define SLS_CODE_TORQUE_BIAS 14'h0006
`define SLS_CODE_FREQ_CMD 14'h0000
`define SLS_TERM_CODE_SECOND 8'h03
`define SLS_TERM_CODE_THIRD 8'h09
`define SLS_RANGE_5V_SEL 4'h0
`define SLS_RANGE_BIPOLAR 4'h1
`define SLS_VRED_ON 1'h0

// Reset values of the parameter settings
`define SLS_VRED_RESET 1'h1

// Analog scaling
`define SLS_FRAC_BITS 12
`define SLS_FRAC_FULL 13'h0FFF
`define SLS_FRAC_ONE 13'h1000

// Fast limit status selector field positions
`define SLS_FLS_OL_ACTION_BIT 4

// Overload minimum hold time
`define SLS_OL_HOLD_MS 100
`define SLS_CLK_KHZ 125000
`define SLS_OL_HOLD_CYCLES (`SLS_OL_HOLD_MS * `SLS_CLK_KHZ + 1)

`endif

// *** rtl/sls_pkg.sv ***
package sls_pkg;
  // Where the stall level was taken from
  typedef enum logic [2:0] {
    SLS_SRC_PRIMARY,
    SLS_SRC_VOLTAGE,
    SLS_SRC_CURRENT,
    SLS_SRC_SECOND,
    SLS_SRC_ZERO
  } sls_src_type;

  // Overload output sequencing
  typedef enum logic [1:0] {
    SLS_OL_IDLE,
    SLS_OL_HOLD,
    SLS_OL_RELEASE
  } sls_ol_state_type;
endpackage

// *** rtl/sls_scale_if.sv ***
`timescale 1ns/100ps
// Carries one analog fraction and both endpoints to the interpolator
interface sls_scale_if #(
  parameter int LEVEL_W = 12
);
  logic [12:0] frac; // 0 to 4096 means 0 to full scale
  logic [LEVEL_W-1:0] low_level; // Level at zero input
  logic [LEVEL_W-1:0] high_level; // Level at full scale
  logic [LEVEL_W-1:0] level; // Interpolated level
  modport calc (input frac, input low_level, input high_level, output level);
  modport user (output frac, output low_level, output high_level, input level);
endinterface

// *** rtl/sls_interp.sv ***
`timescale 1ns/100ps
`include "sls_cfg.svh"
// Linear interpolation between two endpoint levels
module sls_interp #(
  parameter int LEVEL_W = 12
) (
  sls_scale_if.calc sc
);
  logic signed [LEVEL_W:0] span; // High minus low, may be negative
  logic signed [LEVEL_W+14:0] prod; // Span times fraction
  logic signed [LEVEL_W+1:0] sum; // Low plus scaled span

  // Endpoints exact at fraction 0 and 4096
  assign span = $signed({1'b0, sc.high_level}) - $signed({1'b0, sc.low_level});
  assign prod = span * $signed({1'b0, sc.frac});
  assign sum = $signed({2'b00, sc.low_level}) + prod[LEVEL_W+13:`SLS_FRAC_BITS];
  assign sc.level = sum[LEVEL_W-1:0];
endmodule // sls_interp

// *** rtl/sls_stall_level_select.sv ***
`timescale 1ns/100ps
`include "sls_cfg.svh"
// Stall prevention level source selection and overload signalling
module sls_stall_level_select #(
  parameter int LEVEL_W = 12,
  parameter int FREQ_W = 16,
  parameter int NUM_TERMS = 12,
  parameter int OL_HOLD_CYCLES = `SLS_OL_HOLD_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  // Parameter settings
  input wire logic [13:0] voltage_input_function_select,
  input wire logic [13:0] current_input_function_select,
  input wire logic [3:0] analog_range_select,
  input wire logic [LEVEL_W-1:0] primary_stall_level,
  input wire logic [LEVEL_W-1:0] second_stall_level,
  input wire logic [13:0] second_stall_frequency,
  input wire logic [LEVEL_W-1:0] stall_level_low_endpoint,
  input wire logic [LEVEL_W-1:0] stall_level_high_endpoint,
  input wire logic voltage_reduction_select,
  input wire logic [7:0] fast_limit_status_select,
  input wire logic [NUM_TERMS*8-1:0] input_terminal_function_selectors,
  // Digital terminals
  input wire logic second_function_terminal,
  input wire logic [NUM_TERMS-1:0] input_terminals,
  input wire logic current_input_enable,
  // Analog samples and drive state
  input wire logic signed [12:0] voltage_input_sample,
  input wire logic [11:0] current_input_sample,
  input wire logic [FREQ_W-1:0] output_frequency,
  input wire logic [LEVEL_W-1:0] output_power,
  input wire logic [1:0] operating_status,
  // Results
  output logic [LEVEL_W-1:0] stall_level,
  output logic second_function_select,
  output logic third_function_select,
  output logic overload_output,
  output logic overload_action,
  output logic output_voltage_reduce,
  output logic fast_limit_enable,
  output logic voltage_freq_aux_en,
  output logic voltage_flux_en,
  output logic voltage_torque_bias_en,
  output logic voltage_override_pid_en,
  output logic current_freq_cmd_en,
  output logic current_flux_en,
  output logic current_pid_en
);
  localparam logic [31:0] OL_HOLD_LOAD = 32'(OL_HOLD_CYCLES - 1);

  // Selector decode
  logic v_is_stall; // Voltage terminal sets the stall level
  logic c_is_stall; // Current terminal code is 4
  logic c_stall_used; // Current terminal actually sets the level
  logic v_is_aux;
  logic v_is_flux;
  logic v_is_torque;
  logic c_is_freq;
  logic c_is_flux;

  assign v_is_stall = voltage_input_function_select == `SLS_CODE_STALL;
  assign c_is_stall = current_input_function_select == `SLS_CODE_STALL;
  assign c_stall_used = c_is_stall && !v_is_stall;
  assign v_is_aux = voltage_input_function_select == `SLS_CODE_FREQ_AUX;
  assign v_is_flux = voltage_input_function_select == `SLS_CODE_FLUX;
  assign v_is_torque = voltage_input_function_select == `SLS_CODE_TORQUE_BIAS;
  assign c_is_freq = current_input_function_select == `SLS_CODE_FREQ_CMD;
  assign c_is_flux = current_input_function_select == `SLS_CODE_FLUX;

  // Second and third function select routing
  logic [NUM_TERMS-1:0] term_second; // Terminals assigned to second select
  logic [NUM_TERMS-1:0] term_third; // Terminals assigned to third select
  logic second_sel;
  logic third_sel;

  for (genvar t = 0; t < NUM_TERMS; t++) begin : g_term
    // Each terminal carries the select its code names
    assign term_second[t] = input_terminals[t] &&
      (input_terminal_function_selectors[t*8 +: 8] == `SLS_TERM_CODE_SECOND);
    assign term_third[t] = input_terminals[t] &&
      (input_terminal_function_selectors[t*8 +: 8] == `SLS_TERM_CODE_THIRD);
  end

  assign second_sel = second_function_terminal || (|term_second);
  assign third_sel = |term_third;

  // Analog fraction of full scale
  logic [12:0] v_pos; // Voltage clamped at zero
  logic [13:0] v_double; // Voltage doubled for 5V range
  logic [11:0] v_frac12; // Voltage fraction 0 to 4095
  logic [11:0] a_frac12; // Fraction of the terminal in use
  logic [12:0] a_frac; // Fraction with full scale lifted to 4096
  logic use_5v; // 5V scaling on voltage terminal

  assign use_5v = analog_range_select == `SLS_RANGE_5V_SEL;
  assign v_pos = voltage_input_sample[12] ? 13'h0000 : voltage_input_sample;
  assign v_double = {v_pos, 1'b0};
  assign v_frac12 = use_5v ? ((|v_double[13:12]) ? 12'hFFF : v_double[11:0]) :
    ((v_pos[12]) ? 12'hFFF : v_pos[11:0]);
  assign a_frac12 = c_stall_used ? current_input_sample : v_frac12;
  assign a_frac = ({1'b0, a_frac12} == `SLS_FRAC_FULL) ? `SLS_FRAC_ONE :
    {1'b0, a_frac12};

  // Interpolator between both endpoint levels
  sls_scale_if #(.LEVEL_W(LEVEL_W)) scale_bus ();
  assign scale_bus.frac = a_frac;
  assign scale_bus.low_level = stall_level_low_endpoint;
  assign scale_bus.high_level = stall_level_high_endpoint;

  sls_interp #(
    .LEVEL_W(LEVEL_W)
  ) u_interp (
    .sc(scale_bus.calc)
  );

  // Level selection
  logic analog_in_use; // Either terminal drives the level
  logic [LEVEL_W-1:0] base_level; // Level before the second level
  logic freq_mode; // Second level switched by frequency
  logic at_or_above; // Output frequency at or above second frequency
  logic [LEVEL_W-1:0] min_level; // Smaller of base and second
  logic [LEVEL_W-1:0] level_next;
  sls_pkg::sls_src_type src_next;

  assign analog_in_use = v_is_stall || c_is_stall;
  assign base_level = analog_in_use ? scale_bus.level : primary_stall_level;
  assign freq_mode = second_stall_frequency != `SLS_CODE_DISABLE;
  assign at_or_above = output_frequency >= FREQ_W'(second_stall_frequency);
  assign min_level = (second_stall_level < base_level) ? second_stall_level : base_level;

  // Pick the active level and its source
  always_comb begin
    level_next = base_level;
    src_next = v_is_stall ? sls_pkg::SLS_SRC_VOLTAGE :
      (c_stall_used ? sls_pkg::SLS_SRC_CURRENT : sls_pkg::SLS_SRC_PRIMARY);
    if (freq_mode) begin
      if (at_or_above) begin
        // Zero second level forces zero, else smaller wins
        level_next = min_level;
        src_next = (second_stall_level == '0) ? sls_pkg::SLS_SRC_ZERO :
          sls_pkg::SLS_SRC_SECOND;
      end
    end else if (second_sel) begin
      // Second select overrides analog and primary
      level_next = second_stall_level;
      src_next = sls_pkg::SLS_SRC_SECOND;
    end
  end

  // Registered level and source
  sls_pkg::sls_src_type src_reg;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stall_level <= '0;
      src_reg <= sls_pkg::SLS_SRC_PRIMARY;
    end else begin
      stall_level <= level_next;
      src_reg <= src_next;
    end
  end

  // Function enables of both analog terminals
  logic v_aux_next;
  logic v_pid_next;
  logic c_freq_next;
  logic c_pid_next;

  assign v_aux_next = v_is_aux && !v_is_stall;
  assign v_pid_next = !v_is_stall;
  assign c_freq_next = c_is_freq && current_input_enable && !c_is_stall;
  assign c_pid_next = current_input_enable && !c_is_stall;

  // Registered enables and global selects
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      voltage_freq_aux_en <= 1'b0;
      voltage_flux_en <= 1'b0;
      voltage_torque_bias_en <= 1'b0;
      voltage_override_pid_en <= 1'b0;
      current_freq_cmd_en <= 1'b0;
      current_flux_en <= 1'b0;
      current_pid_en <= 1'b0;
      second_function_select <= 1'b0;
      third_function_select <= 1'b0;
    end else begin
      voltage_freq_aux_en <= v_aux_next;
      voltage_flux_en <= v_is_flux;
      voltage_torque_bias_en <= v_is_torque;
      voltage_override_pid_en <= v_pid_next;
      current_freq_cmd_en <= c_freq_next;
      current_flux_en <= c_is_flux;
      current_pid_en <= c_pid_next;
      second_function_select <= second_sel;
      third_function_select <= third_sel;
    end
  end

  // Overload output with minimum hold
  sls_pkg::sls_ol_state_type ol_state_reg;
  sls_pkg::sls_ol_state_type ol_state_next;
  logic [31:0] hold_cnt_reg;
  logic [31:0] hold_cnt_next;
  logic over_level; // Power above the stall level
  logic hold_done;

  assign over_level = output_power > stall_level;
  assign hold_done = hold_cnt_reg == '0;

  // Next overload state
  always_comb begin
    ol_state_next = ol_state_reg;
    hold_cnt_next = hold_cnt_reg;
    case (ol_state_reg)
      sls_pkg::SLS_OL_IDLE: begin
        if (over_level) begin
          ol_state_next = sls_pkg::SLS_OL_HOLD;
          hold_cnt_next = OL_HOLD_LOAD;
        end
      end
      sls_pkg::SLS_OL_HOLD: begin
        // Count out the minimum on time
        if (hold_done) begin
          ol_state_next = sls_pkg::SLS_OL_RELEASE;
        end else begin
          hold_cnt_next = hold_cnt_reg - 32'h0000_0001;
        end
      end
      sls_pkg::SLS_OL_RELEASE: begin
        // Clear once power is back at or below level
        if (!over_level) begin
          ol_state_next = sls_pkg::SLS_OL_IDLE;
        end
      end
      default: begin
        ol_state_next = sls_pkg::SLS_OL_IDLE;
      end
    endcase
  end

  // Status driven fast limit and overload action, overload driven voltage reduction
  logic ol_next;
  logic fast_next;
  logic action_next;
  logic vred_next;

  assign ol_next = ol_state_next != sls_pkg::SLS_OL_IDLE;
  // Fast limit on unless the selector bit of the present status is set
  assign fast_next = !fast_limit_status_select[operating_status];
  assign action_next = ol_next &&
    fast_limit_status_select[`SLS_FLS_OL_ACTION_BIT + operating_status];
  assign vred_next = ol_next && (voltage_reduction_select == `SLS_VRED_ON);

  // Overload state and outputs
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ol_state_reg <= sls_pkg::SLS_OL_IDLE;
      hold_cnt_reg <= '0;
      overload_output <= 1'b0;
      overload_action <= 1'b0;
      output_voltage_reduce <= 1'b0;
      fast_limit_enable <= 1'b0;
    end else begin
      ol_state_reg <= ol_state_next;
      hold_cnt_reg <= hold_cnt_next;
      overload_output <= ol_next;
      overload_action <= action_next;
      output_voltage_reduce <= vred_next;
      fast_limit_enable <= fast_next;
    end
  end
endmodule // sls_stall_level_select

// *** tb/sls_level_sva.sv ***
`timescale 1ns/100ps
`include "sls_cfg.svh"
// Port-level checks of the stall level selector
module sls_level_sva #(
  parameter int LEVEL_W = 12,
  parameter int OL_HOLD_CYCLES = 20
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [13:0] voltage_input_function_select,
  input wire logic [13:0] current_input_function_select,
  input wire logic [3:0] analog_range_select,
  input wire logic [LEVEL_W-1:0] second_stall_level,
  input wire logic [13:0] second_stall_frequency,
  input wire logic [LEVEL_W-1:0] stall_level_low_endpoint,
  input wire logic [LEVEL_W-1:0] stall_level_high_endpoint,
  input wire logic [7:0] fast_limit_status_select,
  input wire logic second_function_terminal,
  input wire logic signed [12:0] voltage_input_sample,
  input wire logic [15:0] output_frequency,
  input wire logic [LEVEL_W-1:0] output_power,
  input wire logic [1:0] operating_status,
  input wire logic [LEVEL_W-1:0] stall_level,
  input wire logic second_function_select,
  input wire logic overload_output,
  input wire logic fast_limit_enable,
  input wire logic voltage_freq_aux_en,
  input wire logic voltage_torque_bias_en,
  input wire logic current_freq_cmd_en,
  input wire logic current_pid_en
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Voltage terminal is the only level source
  wire plain = voltage_input_function_select == `SLS_CODE_STALL
    && second_stall_frequency == `SLS_CODE_DISABLE
    && !second_function_terminal && !second_function_select;
  wire fl_bit = fast_limit_status_select[operating_status]; // Status disable bit
  logic [31:0] hi_cnt; // Cycles the overload output has stood high
  // Count the overload hold
  always_ff @(posedge clk) begin
    if (!rst_n) hi_cnt <= 32'h0;
    else if (overload_output) hi_cnt <= hi_cnt + 32'h1;
    else hi_cnt <= 32'h0;
  end
  sequence sec_held;
    (second_stall_frequency == `SLS_CODE_DISABLE && second_function_terminal) [*2];
  endsequence
  sequence ol_trig;
    !overload_output && output_power > stall_level;
  endsequence
  zero_input_a: assert property (plain && voltage_input_sample <= 0 |=>
    stall_level == $past(stall_level_low_endpoint)) else $error("zero input level");
  full_scale_a: assert property (plain && analog_range_select != 4'h0
    && voltage_input_sample == 13'h0FFF |=> stall_level == $past(stall_level_high_endpoint))
    else $error("full scale level");
  second_level_a: assert property (sec_held |=>
    stall_level == $past(second_stall_level)) else $error("second level");
  zero_high_a: assert property (second_stall_frequency != `SLS_CODE_DISABLE
    && second_stall_level == 0 && output_frequency >= 16'(second_stall_frequency)
    |=> stall_level == 0) else $error("zero level at high freq");
  pin_select_a: assert property (second_function_terminal |=>
    second_function_select) else $error("second pin");
  torque_decode_a: assert property (voltage_input_function_select == 14'h0006 |=>
    voltage_torque_bias_en && !voltage_freq_aux_en) else $error("torque decode");
  cur_kill_a: assert property (current_input_function_select == 14'h0004 |=>
    !current_pid_en && !current_freq_cmd_en) else $error("current uses");
  ol_rise_a: assert property (ol_trig |=> overload_output)
    else $error("overload rise");
  ol_hold_a: assert property ($fell(overload_output) |-> hi_cnt > OL_HOLD_CYCLES)
    else $error("overload hold");
  fast_sel_a: assert property (1'b1 |=> fast_limit_enable == !$past(fl_bit))
    else $error("fast limit select");
endmodule // sls_level_sva

bind sls_stall_level_select sls_level_sva #(.LEVEL_W(LEVEL_W),
  .OL_HOLD_CYCLES(OL_HOLD_CYCLES)) u_sva (.clk(clk), .rst_n(rst_n),
  .voltage_input_function_select(voltage_input_function_select),
  .current_input_function_select(current_input_function_select),
  .analog_range_select(analog_range_select), .second_stall_level(second_stall_level),
  .second_stall_frequency(second_stall_frequency),
  .stall_level_low_endpoint(stall_level_low_endpoint),
  .stall_level_high_endpoint(stall_level_high_endpoint),
  .fast_limit_status_select(fast_limit_status_select),
  .second_function_terminal(second_function_terminal),
  .voltage_input_sample(voltage_input_sample), .output_frequency(output_frequency),
  .output_power(output_power), .operating_status(operating_status),
  .stall_level(stall_level), .second_function_select(second_function_select),
  .overload_output(overload_output), .fast_limit_enable(fast_limit_enable),
  .voltage_freq_aux_en(voltage_freq_aux_en), .voltage_torque_bias_en(voltage_torque_bias_en),
  .current_freq_cmd_en(current_freq_cmd_en), .current_pid_en(current_pid_en));

// *** tb/sls_analog_src.sv ***
`timescale 1ns/100ps
// Analog terminals: volts and amps turned into converter codes
module sls_analog_src (
  input wire logic [15:0] volt_mv,
  input wire logic [15:0] curr_ua,
  output logic signed [12:0] voltage_input_sample,
  output logic [11:0] current_input_sample
);
  // Rounded up so that full scale reaches the top code
  assign voltage_input_sample = 13'((32'(volt_mv) * 4095 + 9999) / 10000);
  assign current_input_sample = 12'((32'(curr_ua) * 4095 + 19999) / 20000);
endmodule // sls_analog_src

// *** tb/sls_stall_level_select_tb.sv ***
`timescale 1ns/100ps
`include "sls_cfg.svh"
// Self-checking bench of the stall level selector
module sls_stall_level_select_tb;
  logic clk, rst_n, vred, spin, cen;
  logic [13:0] vsel, csel, sfrq;
  logic [3:0] rng;
  logic [11:0] prim, slvl, low, high, pwr, terms, lvl;
  logic [7:0] fls;
  logic [95:0] itfs;
  logic [15:0] mv, ua, ofrq;
  logic [1:0] ost;
  logic signed [12:0] vs;
  logic [11:0] cs;
  logic sfs, tfs, ol, ola, ovr, fle, vaux, vflux, vtb, vpid, cfc, cflux, cpid;
  int fail_count = 0;
  int compares = 0;
  sls_analog_src src (.volt_mv(mv), .curr_ua(ua), .voltage_input_sample(vs),
    .current_input_sample(cs));
  sls_stall_level_select #(.OL_HOLD_CYCLES(20)) dut (.clk(clk), .rst_n(rst_n),
    .voltage_input_function_select(vsel), .current_input_function_select(csel),
    .analog_range_select(rng), .primary_stall_level(prim), .second_stall_level(slvl),
    .second_stall_frequency(sfrq), .stall_level_low_endpoint(low),
    .stall_level_high_endpoint(high), .voltage_reduction_select(vred),
    .fast_limit_status_select(fls), .input_terminal_function_selectors(itfs),
    .second_function_terminal(spin), .input_terminals(terms), .current_input_enable(cen),
    .voltage_input_sample(vs), .current_input_sample(cs), .output_frequency(ofrq),
    .output_power(pwr), .operating_status(ost), .stall_level(lvl),
    .second_function_select(sfs), .third_function_select(tfs), .overload_output(ol),
    .overload_action(ola), .output_voltage_reduce(ovr), .fast_limit_enable(fle),
    .voltage_freq_aux_en(vaux), .voltage_flux_en(vflux), .voltage_torque_bias_en(vtb),
    .voltage_override_pid_en(vpid), .current_freq_cmd_en(cfc), .current_flux_en(cflux),
    .current_pid_en(cpid));
  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Compare a level
  task automatic chk_val(string nm, logic [11:0] exp, logic [11:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %0d seen %0d", nm, exp, got);
    end
  endtask
  // Compare a flag
  task automatic chk_bit(string nm, logic exp, logic got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %b seen %b", nm, exp, got);
    end
  endtask
  // Two falling edges: one register stage plus select settling
  task automatic settle;
    repeat (2) @(negedge clk);
  endtask
  task automatic finish_test;
    $display("Counts: %0d compares, %0d mismatches", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Analog sources, ranges, priority
  task automatic t_analog;
    vsel = `SLS_CODE_STALL;
    mv = 16'h0000;
    settle();
    chk_val("zero volts", 12'h064, lvl);
    mv = 16'h1388;
    settle();
    chk_val("half scale", 12'h12C, lvl);
    mv = 16'h2710;
    settle();
    chk_val("ten volts", 12'h1F4, lvl);
    chk_bit("fast limit fixed", 1'b1, fle);
    rng = `SLS_RANGE_5V_SEL;
    mv = 16'h1388;
    settle();
    chk_val("five volts", 12'h1F4, lvl);
    mv = 16'h09C4;
    settle();
    chk_val("half of five", 12'h12C, lvl);
    vsel = 14'h0000;
    csel = `SLS_CODE_STALL;
    ua = 16'h4E20;
    settle();
    chk_val("twenty ma", 12'h1F4, lvl);
    vsel = `SLS_CODE_STALL;
    mv = 16'h0000;
    settle();
    chk_val("voltage wins", 12'h064, lvl);
    rng = `SLS_RANGE_BIPOLAR;
    $display("analog test done");
  endtask
  // Terminal function decode
  task automatic t_decode;
    logic [13:0] vc[5] = '{14'h0000, 14'h0001, 14'h0004, 14'h0006, 14'h0005};
    logic [3:0] ve[5] = '{4'h9, 4'h5, 4'h0, 4'h3, 4'h1};
    logic [13:0] cc[4] = '{14'h0000, 14'h0001, 14'h0004, `SLS_CODE_DISABLE};
    logic [2:0] ce[4] = '{3'h5, 3'h3, 3'h0, 3'h1};
    cen = 1'b1;
    for (int i = 0; i < 5; i++) begin
      vsel = vc[i];
      csel = cc[i % 4];
      settle();
      chk_val("voltage uses", 12'(ve[i]), 12'({vaux, vflux, vtb, vpid}));
      chk_val("current uses", 12'(ce[i % 4]), 12'({cfc, cflux, cpid}));
    end
    vsel = 14'h0000;
    csel = `SLS_CODE_DISABLE;
    $display("decode test done");
  endtask
  // Second selects and second level
  task automatic t_second;
    spin = 1'b1;
    settle();
    chk_bit("pin select", 1'b1, sfs);
    chk_val("second level", 12'h032, lvl);
    spin = 1'b0;
    itfs[47:40] = `SLS_TERM_CODE_SECOND;
    terms[5] = 1'b1;
    itfs[23:16] = `SLS_TERM_CODE_THIRD;
    terms[2] = 1'b1;
    settle();
    chk_bit("coded select", 1'b1, sfs);
    chk_bit("third select", 1'b1, tfs);
    terms = 12'h000;
    sfrq = 14'h0258;
    slvl = 12'h000;
    ofrq = 16'h0258;
    settle();
    chk_bit("select off", 1'b0, sfs);
    chk_val("zero at freq", 12'h000, lvl);
    ofrq = 16'h0257;
    settle();
    chk_val("below freq", 12'h12C, lvl);
    sfrq = `SLS_CODE_DISABLE;
    slvl = 12'h032;
    $display("second test done");
  endtask
  // Overload hold, voltage reduction, fast limit
  task automatic t_overload;
    int n;
    pwr = 12'h190;
    vred = `SLS_VRED_ON;
    fls = 8'h10;
    settle();
    chk_bit("overload on", 1'b1, ol);
    chk_bit("reduce", 1'b1, ovr);
    chk_bit("action", 1'b1, ola);
    pwr = 12'h064;
    n = 2;
    while (ol === 1'b1 && n < 60) begin
      @(negedge clk);
      n++;
    end
    chk_val("hold length", 12'h016, 12'(n));
    chk_bit("reduce off", 1'b0, ovr);
    vred = `SLS_VRED_RESET;
    pwr = 12'h190;
    fls = 8'h5A;
    for (int s = 0; s < 4; s++) begin
      ost = 2'(s);
      settle();
      chk_bit("fast limit", ~fls[s], fle);
      chk_bit("status action", fls[4 + s], ola);
      chk_bit("no reduce", 1'b0, ovr);
    end
    pwr = 12'h064;
    $display("overload test done");
  endtask
  // Main sequence
  initial begin
    {rst_n, spin, cen} = 3'h0;
    vred = `SLS_VRED_RESET;
    vsel = 14'h0000;
    csel = `SLS_CODE_DISABLE;
    sfrq = `SLS_CODE_DISABLE;
    rng = `SLS_RANGE_BIPOLAR;
    {prim, slvl, low, high} = {12'h12C, 12'h032, 12'h064, 12'h1F4};
    {pwr, terms, fls, ost} = '0;
    {itfs, mv, ua, ofrq} = '0;
    repeat (12) @(negedge clk);
    chk_val("reset level", 12'h000, lvl);
    chk_bit("reset overload", 1'b0, ol);
    rst_n = 1'b1;
    $display("reset test done");
    t_analog();
    t_decode();
    t_second();
    t_overload();
    finish_test();
  end
endmodule // sls_stall_level_select_tb
